// ### hw/rxev_pkg.sv
// ****************************************************************
// register map and constants of the receive event/filter bank
// ****************************************************************
package rxev_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] RXEV_IDX_FILL_STAT = 8'h0E; // fill_and_event_status
   localparam logic [7:0] RXEV_IDX_THRESH = 8'h0F;    // signal_threshold
   localparam logic [7:0] RXEV_IDX_FILTER = 8'h10;    // rx_filter_bandwidth
   localparam logic [7:0] RXEV_IDX_IRQ_STAT = 8'h20;  // sticky event status
   localparam logic [7:0] RXEV_IDX_IRQ_CLR = 8'h21;   // write-only clear
   localparam logic [7:0] RXEV_IDX_IRQ_EN = 8'h22;    // event enable

   // byte addresses on the bus, word aligned
   localparam logic [9:0] RXEV_ADDR_FILL_STAT = {RXEV_IDX_FILL_STAT, 2'b00};
   localparam logic [9:0] RXEV_ADDR_THRESH = {RXEV_IDX_THRESH, 2'b00};
   localparam logic [9:0] RXEV_ADDR_FILTER = {RXEV_IDX_FILTER, 2'b00};
   localparam logic [9:0] RXEV_ADDR_IRQ_STAT = {RXEV_IDX_IRQ_STAT, 2'b00};
   localparam logic [9:0] RXEV_ADDR_IRQ_CLR = {RXEV_IDX_IRQ_CLR, 2'b00};
   localparam logic [9:0] RXEV_ADDR_IRQ_EN = {RXEV_IDX_IRQ_EN, 2'b00};

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RXEV_RST_FILL_STAT = 8'h01;
   localparam logic [7:0] RXEV_RST_THRESH = 8'h00;
   localparam logic [3:0] RXEV_RST_LOWPASS = 4'hA;
   localparam logic [3:0] RXEV_RST_CUTOFF = 4'h3;
   localparam logic [4:0] RXEV_RST_IRQ_EN = 5'h00;

   // ****************************************************************
   // fill_and_event_status bit positions
   // ****************************************************************
   localparam int RXEV_B_FILL_MODE = 7;   // fill mode select
   localparam int RXEV_B_FILL_START = 6;  // fill start / pattern seen
   localparam int RXEV_B_TX_DONE = 5;     // last bit sent to modulator
   localparam int RXEV_B_OVERFLOW = 4;    // queue_overflow_clear
   localparam int RXEV_B_STR_EN = 3;      // strength_event_enable
   localparam int RXEV_B_SIG = 2;         // signal_present_flag
   localparam int RXEV_B_LOCK = 1;        // synth_lock_flag
   localparam int RXEV_B_LOCK_PIN = 0;    // lock output enable

   // rx_filter_bandwidth field positions
   localparam int RXEV_F_LOWPASS_LSB = 4;
   localparam int RXEV_F_CUTOFF_LSB = 0;

   // ****************************************************************
   // interrupt status bit positions
   // ****************************************************************
   localparam int RXEV_NUM_EVT = 5;
   localparam int RXEV_E_SIG = 0;         // signal present set
   localparam int RXEV_E_LOCK = 1;        // synthesizer locked
   localparam int RXEV_E_PATTERN = 2;     // start pattern seen
   localparam int RXEV_E_OVERFLOW = 3;    // queue overflowed
   localparam int RXEV_E_TX_DONE = 4;     // transmit finished

   // ****************************************************************
   // data path modes and cutoff formula terms
   // ****************************************************************
   typedef enum logic [1:0] {
      RXEV_MODE_CONT = 2'h0,
      RXEV_MODE_BUF = 2'h1,
      RXEV_MODE_PKT = 2'h2
   } rxev_mode_e;

   localparam int RXEV_CUT_BASE_KHZ = 200;    // cutoff scale in kHz
   localparam int RXEV_CUT_XTAL_KHZ = 12800;  // nominal crystal in kHz
   localparam int RXEV_CUT_STEPS = 8;         // divisor of (J + 1)
   localparam logic [3:0] RXEV_OOK_J_MAX = 4'h1; // top usable OOK code

endpackage : rxev_pkg

// ### hw/rxev_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rxev_regs
   import rxev_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // radio status inputs
   input wire logic [7:0] rssi_level,
   input wire logic start_pattern_hit,
   input wire logic synth_locked,
   input wire logic tx_last_bit_done,
   input wire logic queue_overflowed,
   input wire logic [1:0] data_mode,
   // radio control outputs
   output logic fifo_fill_en,
   output logic queue_flush,
   output logic packet_restart,
   output logic pattern_rearm,
   output logic lock_pin,
   output logic [3:0] lowpass_bandwidth_sel,
   output logic [3:0] filter_cutoff_sel,
   output logic ook_cutoff_invalid,
   // interrupt
   output logic irq
);

   // ****************************************************************
   // bus slave state
   // ****************************************************************
   typedef enum logic [1:0] {
      RXEV_ST_IDLE = 2'b01,   // waiting for an address phase
      RXEV_ST_DATA = 2'b10    // one wait state, then answer
   } rxev_bus_e;

   rxev_bus_e state_ff; // slave state
   rxev_bus_e nxt_state; // next slave state
   logic [9:0] addr_ff; // latched word address
   logic wr_ff; // latched direction
   logic hreadyout_ff; // ready to master
   logic [31:0] hrdata_ff; // registered read data
   logic take; // address phase accepted
   logic wr_do; // write lands this cycle
   logic [7:0] wbyte; // low byte of write data

   // ****************************************************************
   // register state
   // ****************************************************************
   logic fill_mode_ff; // fill mode select
   logic fill_start_ff; // fill start / pattern seen
   logic str_en_ff; // strength_event_enable
   logic lock_pin_en_ff; // lock output enable
   logic [7:0] strength_threshold_ff; // comparison level
   logic [3:0] lowpass_ff; // lowpass_bandwidth_sel
   logic [3:0] cutoff_ff; // filter_cutoff_sel
   logic [4:0] irq_en_ff; // event enables
   logic tx_done_ff; // registered tx done level
   logic lock_prev_ff; // previous lock level for edge
   logic flush_ff; // one-cycle flush pulse
   logic restart_ff; // one-cycle packet restart pulse
   logic rearm_ff; // one-cycle pattern rearm pulse
   logic lock_pin_ff; // lock pin drive
   logic irq_ff; // interrupt line
   logic ook_bad_ff; // cutoff outside OOK range
   logic fill_en_ff; // registered fill enable

   // ****************************************************************
   // flag wiring
   // ****************************************************************
   logic sig_set; // signal present condition
   logic lock_set; // lock rising edge
   logic sig_q; // signal_present_flag
   logic lock_q; // synth_lock_flag
   logic ovf_q; // overflow flag
   logic [4:0] evt; // event pulses into status
   logic [4:0] evt_clr; // clear strobes for status
   logic [4:0] irq_stat; // sticky event status
   logic [7:0] fill_stat_rd; // read view of status register
   logic wr_fill; // write to fill_and_event_status
   logic pattern_set; // pattern recognized in mode 0

   // ****************************************************************
   // bus decode
   // ****************************************************************
   // only word transfers are used, so hsize is not examined
   assign take = hsel && htrans[1] && hready;
   assign wr_do = (state_ff == RXEV_ST_DATA) && wr_ff;
   assign wbyte = hwdata[7:0];
   assign wr_fill = wr_do && (addr_ff == RXEV_ADDR_FILL_STAT);

   // next state of the slave
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         RXEV_ST_IDLE: begin
            if (take) begin
               nxt_state = RXEV_ST_DATA;
            end
         end
         RXEV_ST_DATA: begin
            nxt_state = RXEV_ST_IDLE;
         end
         default: begin
            nxt_state = RXEV_ST_IDLE;
         end
      endcase
   end

   // slave state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= RXEV_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // address and direction capture
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         addr_ff <= 10'h000;
         wr_ff <= 1'b0;
      end else if ((state_ff == RXEV_ST_IDLE) && take) begin
         addr_ff <= {haddr[9:2], 2'b00};
         wr_ff <= hwrite;
      end else if (state_ff == RXEV_ST_DATA) begin
         wr_ff <= 1'b0;
      end
   end

   // ready drops for one cycle of every data phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout_ff <= 1'b1;
      end else if ((state_ff == RXEV_ST_IDLE) && take) begin
         hreadyout_ff <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
      end
   end

   // read view of the status register
   always_comb begin
      fill_stat_rd = 8'h00;
      fill_stat_rd[RXEV_B_FILL_MODE] = fill_mode_ff;
      fill_stat_rd[RXEV_B_FILL_START] = fill_start_ff;
      fill_stat_rd[RXEV_B_TX_DONE] = tx_done_ff;
      fill_stat_rd[RXEV_B_OVERFLOW] = ovf_q;
      fill_stat_rd[RXEV_B_STR_EN] = str_en_ff;
      fill_stat_rd[RXEV_B_SIG] = sig_q;
      fill_stat_rd[RXEV_B_LOCK] = lock_q;
      fill_stat_rd[RXEV_B_LOCK_PIN] = lock_pin_en_ff;
   end

   // read data, unmapped words read zero
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if ((state_ff == RXEV_ST_DATA) && !wr_ff) begin
         case (addr_ff)
            RXEV_ADDR_FILL_STAT: hrdata_ff <= {24'h000000, fill_stat_rd};
            RXEV_ADDR_THRESH: hrdata_ff <= {24'h000000, strength_threshold_ff};
            RXEV_ADDR_FILTER: hrdata_ff <= {24'h000000, lowpass_ff, cutoff_ff};
            RXEV_ADDR_IRQ_STAT: hrdata_ff <= {27'h0000000, irq_stat};
            RXEV_ADDR_IRQ_EN: hrdata_ff <= {27'h0000000, irq_en_ff};
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // plain read/write fields
   // ****************************************************************
   // configuration bits of the status register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         fill_mode_ff <= RXEV_RST_FILL_STAT[RXEV_B_FILL_MODE];
         str_en_ff <= RXEV_RST_FILL_STAT[RXEV_B_STR_EN];
         lock_pin_en_ff <= RXEV_RST_FILL_STAT[RXEV_B_LOCK_PIN];
      end else if (wr_fill) begin
         fill_mode_ff <= wbyte[RXEV_B_FILL_MODE];
         str_en_ff <= wbyte[RXEV_B_STR_EN];
         lock_pin_en_ff <= wbyte[RXEV_B_LOCK_PIN];
      end
   end

   // strength threshold
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strength_threshold_ff <= RXEV_RST_THRESH;
      end else if (wr_do && (addr_ff == RXEV_ADDR_THRESH)) begin
         strength_threshold_ff <= wbyte;
      end
   end

   // filter selects; codes pass to the analog filters unchanged
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lowpass_ff <= RXEV_RST_LOWPASS;
         cutoff_ff <= RXEV_RST_CUTOFF;
      end else if (wr_do && (addr_ff == RXEV_ADDR_FILTER)) begin
         lowpass_ff <= wbyte[RXEV_F_LOWPASS_LSB +: 4];
         cutoff_ff <= wbyte[RXEV_F_CUTOFF_LSB +: 4];
      end
   end

   // ook range warning: codes above one are not usable there
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ook_bad_ff <= (RXEV_RST_CUTOFF > RXEV_OOK_J_MAX);
      end else begin
         ook_bad_ff <= (cutoff_ff > RXEV_OOK_J_MAX);
      end
   end

   // interrupt enables
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_en_ff <= RXEV_RST_IRQ_EN;
      end else if (wr_do && (addr_ff == RXEV_ADDR_IRQ_EN)) begin
         irq_en_ff <= wbyte[4:0];
      end
   end

   // ****************************************************************
   // fill start bit and queue fill
   // ****************************************************************
   assign pattern_set = !fill_mode_ff && start_pattern_hit;
   // mode 0: pattern sets, write one clears (pattern wins);
   // mode 1: software owns the bit directly
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         fill_start_ff <= RXEV_RST_FILL_STAT[RXEV_B_FILL_START];
      end else if (pattern_set) begin
         fill_start_ff <= 1'b1;
      end else if (wr_fill && !fill_mode_ff) begin
         if (wbyte[RXEV_B_FILL_START]) begin
            fill_start_ff <= 1'b0;
         end
      end else if (wr_fill) begin
         fill_start_ff <= wbyte[RXEV_B_FILL_START];
      end
   end

   // rearm pulse for the pattern matcher on a write of one in mode 0
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rearm_ff <= 1'b0;
      end else begin
         rearm_ff <= wr_fill && !fill_mode_ff
            && wbyte[RXEV_B_FILL_START];
      end
   end

   // both modes fill while the start bit is high
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         fill_en_ff <= 1'b0;
      end else begin
         fill_en_ff <= fill_start_ff;
      end
   end

   // ****************************************************************
   // overflow flag and flush
   // ****************************************************************
   // flush only in buffered and packet modes
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flush_ff <= 1'b0;
         restart_ff <= 1'b0;
      end else begin
         flush_ff <= wr_fill && wbyte[RXEV_B_OVERFLOW]
            && ((data_mode == RXEV_MODE_BUF)
            || (data_mode == RXEV_MODE_PKT));
         restart_ff <= wr_fill && wbyte[RXEV_B_OVERFLOW]
            && (data_mode == RXEV_MODE_PKT);
      end
   end

   rxev_sticky u_ovf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set(queue_overflowed),
      .clr(wr_fill && wbyte[RXEV_B_OVERFLOW]),
      .q(ovf_q)
   );

   // ****************************************************************
   // signal present and lock flags
   // ****************************************************************
   assign sig_set = str_en_ff
      && (rssi_level >= strength_threshold_ff);
   assign lock_set = synth_locked && !lock_prev_ff;
   // lock history and tx level sampling
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lock_prev_ff <= 1'b0;
         tx_done_ff <= 1'b0;
      end else begin
         lock_prev_ff <= synth_locked;
         tx_done_ff <= tx_last_bit_done;
      end
   end

   rxev_sticky u_sig (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set(sig_set),
      .clr(wr_fill && wbyte[RXEV_B_SIG]),
      .q(sig_q)
   );

   rxev_sticky u_lock (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set(lock_set),
      .clr(wr_fill && wbyte[RXEV_B_LOCK]),
      .q(lock_q)
   );

   // lock pin idles high when disabled
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lock_pin_ff <= 1'b1;
      end else begin
         lock_pin_ff <= lock_pin_en_ff ? synth_locked : 1'b1;
      end
   end

   // ****************************************************************
   // interrupt status, clear and enable
   // ****************************************************************
   // events: rising edges of lock and tx done, signal set while its flag is clear, pattern hit in fill mode 0 only, overflow input as it stands
   always_comb begin
      evt = 5'h00;
      evt[RXEV_E_SIG] = sig_set && !sig_q;
      evt[RXEV_E_LOCK] = lock_set;
      evt[RXEV_E_PATTERN] = pattern_set;
      evt[RXEV_E_OVERFLOW] = queue_overflowed;
      evt[RXEV_E_TX_DONE] = tx_last_bit_done && !tx_done_ff;
   end

   assign evt_clr = (wr_do && (addr_ff == RXEV_ADDR_IRQ_CLR)) ?
      wbyte[4:0] : 5'h00;
   genvar gi;
   generate
      for (gi = 0; gi < RXEV_NUM_EVT; gi = gi + 1) begin : g_stat
         rxev_sticky u_stat (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .set(evt[gi]),
            .clr(evt_clr[gi]),
            .q(irq_stat[gi])
         );
      end
   endgenerate

   // level interrupt while any enabled bit stands
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_stat & irq_en_ff);
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;
   assign fifo_fill_en = fill_en_ff;
   assign queue_flush = flush_ff;
   assign packet_restart = restart_ff;
   assign pattern_rearm = rearm_ff;
   assign lock_pin = lock_pin_ff;
   assign lowpass_bandwidth_sel = lowpass_ff;
   assign filter_cutoff_sel = cutoff_ff;
   assign ook_cutoff_invalid = ook_bad_ff;
   assign irq = irq_ff;

endmodule // rxev_regs
`default_nettype wire

// ### hw/rxev_sticky.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// sticky flag: hardware set beats software clear
// ****************************************************************
module rxev_sticky (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic set,
   input wire logic clr,
   // state
   output logic q
);

   logic flag_ff; // held flag

   // set wins so an event in the clearing cycle is kept
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flag_ff <= 1'b0;
      end else if (set) begin
         flag_ff <= 1'b1;
      end else if (clr) begin
         flag_ff <= 1'b0;
      end
   end

   assign q = flag_ff;

endmodule // rxev_sticky
`default_nettype wire

// ### verification/rxev_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// radio front end feeding the register bank
// ****************************************************************
module rxev_radio_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // requests from the bench
   input wire logic [7:0] rssi_req,
   input wire logic lock_req,
   input wire logic hit_req,
   input wire logic ovf_req,
   input wire logic done_req,
   // status toward the bank
   output logic [7:0] rssi_level,
   output logic synth_locked,
   output logic start_pattern_hit,
   output logic queue_overflowed,
   output logic tx_last_bit_done
);
   // launched off the clock so the bank never sees a mid-cycle edge
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {rssi_level, synth_locked, start_pattern_hit} <= '0;
         {queue_overflowed, tx_last_bit_done} <= '0;
      end else begin
         rssi_level <= rssi_req;
         synth_locked <= lock_req;
         start_pattern_hit <= hit_req;
         queue_overflowed <= ovf_req;
         tx_last_bit_done <= done_req;
      end
   end
endmodule // rxev_radio_model
`default_nettype wire

// ### verification/rxev_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port-level checks of the receive event/filter bank
// ****************************************************************
module rxev_regs_props
   import rxev_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // radio side
   input wire logic synth_locked,
   input wire logic [1:0] data_mode,
   input wire logic queue_flush,
   input wire logic packet_restart,
   input wire logic pattern_rearm,
   input wire logic lock_pin,
   input wire logic [3:0] lowpass_bandwidth_sel,
   input wire logic [3:0] filter_cutoff_sel,
   input wire logic ook_cutoff_invalid
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // address phase accepted
   sequence s_taken;
      hsel && htrans[1] && hready;
   endsequence
   // data phase ends in this cycle
   sequence s_wr_done;
      hreadyout && $past(!hreadyout);
   endsequence
   a_bus_ready_pulse: assert property (s_taken |=> !hreadyout ##1 hreadyout)
      else $error("wait state not exactly one cycle");
   a_resp_always_okay: assert property (!hresp)
      else $error("error response seen");
   a_flush_by_write: assert property (
      queue_flush |-> s_wr_done ##0 $past(hwdata[4]))
      else $error("flush without overflow write");
   a_flush_not_cont: assert property (
      queue_flush |-> $past(data_mode) != RXEV_MODE_CONT)
      else $error("flush in continuous mode");
   a_restart_pkt_only: assert property (
      packet_restart |-> queue_flush && $past(data_mode) == RXEV_MODE_PKT)
      else $error("restart outside packet flush");
   a_rearm_by_write: assert property (
      pattern_rearm |-> s_wr_done ##0 $past(hwdata[6]) ##1 !pattern_rearm)
      else $error("rearm pulse wrong");
   a_lock_pin_src: assert property (
      !lock_pin |-> !$past(synth_locked))
      else $error("lock pin low while locked");
   // two quiet cycles let a registered flag catch up
   a_ook_code_flag: assert property (
      $stable(filter_cutoff_sel) ##1 $stable(filter_cutoff_sel)
      |-> ook_cutoff_invalid == (filter_cutoff_sel > 4'h1))
      else $error("ook flag disagrees with code");
   a_filter_by_bus: assert property (
      ($changed(filter_cutoff_sel) || $changed(lowpass_bandwidth_sel))
      |-> $past(!hreadyout))
      else $error("filter field moved without write");
   a_rdata_stands: assert property ($changed(hrdata) |-> $past(!hreadyout))
      else $error("read data moved outside transfer");
endmodule // rxev_regs_props
bind rxev_regs rxev_regs_props rxev_regs_props_inst (.ref_clk, .resetn,
   .hsel, .htrans, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
   .synth_locked, .data_mode, .queue_flush, .packet_restart,
   .pattern_rearm, .lock_pin, .lowpass_bandwidth_sel,
   .filter_cutoff_sel, .ook_cutoff_invalid);
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench of the receive event/filter bank
// ****************************************************************
module testbench;
   import rxev_pkg::*;
   logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, data_mode;
   logic [2:0] hsize;
   logic [7:0] rssi_req, rssi_level;
   logic lock_req, hit_req, ovf_req, done_req, fl, rs, ra;
   logic synth_locked, start_pattern_hit, tx_last_bit_done;
   logic queue_overflowed, fifo_fill_en, queue_flush, packet_restart;
   logic pattern_rearm, lock_pin, ook_cutoff_invalid;
   logic [3:0] lowpass_bandwidth_sel, filter_cutoff_sel;
   int err_count = 0, num_checks = 0, cyc = 0, r;
   int seed = 32'hB8CB012D; // fixed so every run repeats
   localparam logic [9:0] fs = RXEV_ADDR_FILL_STAT;
   rxev_regs rxev_regs_inst (.ref_clk, .resetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .rssi_level, .start_pattern_hit, .synth_locked,
      .tx_last_bit_done, .queue_overflowed, .data_mode, .fifo_fill_en,
      .queue_flush, .packet_restart, .pattern_rearm, .lock_pin,
      .lowpass_bandwidth_sel, .filter_cutoff_sel, .ook_cutoff_invalid,
      .irq);
   rxev_radio_model rxev_radio_model_inst (.ref_clk, .resetn, .rssi_req,
      .lock_req, .hit_req, .ovf_req, .done_req, .rssi_level, .synth_locked,
      .start_pattern_hit, .queue_overflowed, .tx_last_bit_done);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one ahb single transfer; pulses seen in the data phase are kept
   task automatic bus(input logic wr, input logic [9:0] a,
                      input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, a};
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      {fl, rs, ra} = 3'h0;
      do begin
         @(posedge ref_clk);
         {fl, rs, ra} = {fl, rs, ra} | {queue_flush, packet_restart,
                                        pattern_rearm};
      end while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {resetn, hsel, hwrite, lock_req, hit_req, ovf_req, done_req} = '0;
      {haddr, hwdata, htrans, data_mode, rssi_req} = '0;
      hsize = 3'h2;
      tick(8);
      resetn <= 1'b1;
      tick(1);
      rd(fs, 8'h01);
      rd(RXEV_ADDR_THRESH, 8'h00);
      rd(RXEV_ADDR_FILTER, 8'hA3);
      rd(RXEV_ADDR_IRQ_EN, 8'h00);
      rd(10'h3FC, 8'h00);
      chk(lock_pin, 1'b0);
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         if (i < 2) r[15:8] = i ? 8'h02 : 8'hF1;
         bus(1'b1, RXEV_ADDR_THRESH, r[7:0]);
         bus(1'b1, RXEV_ADDR_FILTER, r[15:8]);
         rd(RXEV_ADDR_THRESH, r[7:0]);
         rd(RXEV_ADDR_FILTER, r[15:8]);
         chk({lowpass_bandwidth_sel, filter_cutoff_sel}, r[15:8]);
         chk(ook_cutoff_invalid, r[11:9] != 3'h0);
      end
      $display("config fields done");
      bus(1'b1, RXEV_ADDR_THRESH, 8'h40);
      rssi_req <= 8'h7F;
      tick(3);
      rd(fs, 8'h01);
      rssi_req <= 8'h3F;
      tick(3);
      bus(1'b1, fs, 8'h09);
      rd(fs, 8'h09);
      rssi_req <= 8'h40;
      tick(3);
      rssi_req <= 8'h00;
      tick(3);
      rd(fs, 8'h0D);
      bus(1'b1, fs, 8'h09);
      rd(fs, 8'h0D);
      rd(RXEV_ADDR_IRQ_STAT, 8'h01);
      chk(irq, 1'b0);
      bus(1'b1, RXEV_ADDR_IRQ_EN, 8'h01);
      tick(2);
      chk(irq, 1'b1);
      bus(1'b1, RXEV_ADDR_IRQ_CLR, 8'h01);
      tick(2);
      chk(irq, 1'b0);
      rd(RXEV_ADDR_IRQ_CLR, 8'h00);
      bus(1'b1, fs, 8'h0D);
      rd(fs, 8'h09);
      $display("signal detect done");
      lock_req <= 1'b1;
      tick(3);
      rd(fs, 8'h0B);
      chk({lock_pin, irq}, 2'b10);
      bus(1'b1, fs, 8'h08);
      lock_req <= 1'b0;
      tick(3);
      chk(lock_pin, 1'b1);
      rd(fs, 8'h0A);
      bus(1'b1, fs, 8'h0A);
      rd(fs, 8'h08);
      $display("lock flag done");
      hit_req <= 1'b1;
      tick(1);
      hit_req <= 1'b0;
      tick(3);
      rd(fs, 8'h48);
      chk(fifo_fill_en, 1'b1);
      bus(1'b1, fs, 8'h48);
      chk(ra, 1'b1);
      tick(2);
      chk(fifo_fill_en, 1'b0);
      bus(1'b1, fs, 8'h88);
      bus(1'b1, fs, 8'hC8);
      tick(2);
      chk(fifo_fill_en, 1'b1);
      bus(1'b1, fs, 8'h88);
      tick(2);
      chk(fifo_fill_en, 1'b0);
      bus(1'b1, fs, 8'h08);
      $display("fill modes done");
      for (int m = 0; m < 3; m++) begin
         data_mode <= m[1:0];
         ovf_req <= 1'b1;
         tick(1);
         ovf_req <= 1'b0;
         tick(3);
         rd(fs, 8'h18);
         bus(1'b1, fs, 8'h18);
         chk({fl, rs}, {m != 0, m == 2});
         rd(fs, 8'h08);
      end
      done_req <= 1'b1;
      tick(3);
      rd(fs, 8'h28);
      done_req <= 1'b0;
      tick(3);
      rd(fs, 8'h08);
      $display("overflow and transmit done");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
